// *** core/emi_core.sv ***
// external memory controller: three async chip selects and one sdram select
`timescale 1ns/1ps
// Overview of operation
// - three async selects drive chip-select outputs for regions two to four
// - each async select has its own width, timing, turnaround, wait and strobe settings
// - wait input from slow memory stretches the current async access
// - one separate chip select, number zero, serves the sdram
// - sdram data bus is 32 or 16 bits by configuration
// - sdram with one, two or four banks gets matching bank address
// - sdram column width 8 to 11 bits splits the address
// - sdram read latency of two or three cycles by configuration
// - sdram can be put in self-refresh and power-down
// - in power-down the controller wakes periodically to refresh
// - no sdram bursts: every access is single with full latency
// - without extended wait a read lasts setup plus strobe plus hold
// - with extended wait each counted wait unit adds sixteen cycles
// - select-strobe off: select spans setup and hold around output enable
// - select-strobe on: select follows the strobe itself
// - read bank and address valid setup before and hold after enable
// - wait must come four cycles before hold; wait cycles not counted there
// - lengths span documented ranges, read strobe at least four cycles
// - write address, bank, mask and data valid setup before, hold after enable
module emi_core
   import emi_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // request side
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic req_sdram,
   input wire logic [1:0] req_cs,
   input wire logic [23:0] req_addr,
   input wire logic [31:0] req_wdata,
   input wire logic [3:0] req_be,
   output logic req_ready,
   output logic rsp_valid,
   output logic [31:0] rsp_rdata,
   output logic rsp_timeout,
   // async settings, index 0 is select two
   input wire logic [2:0] async_wide,
   input wire logic [2:0][3:0] read_setup_cycles,
   input wire logic [2:0][5:0] read_strobe_cycles,
   input wire logic [2:0][2:0] read_hold_cycles,
   input wire logic [2:0][3:0] write_setup_cycles,
   input wire logic [2:0][5:0] write_strobe_cycles,
   input wire logic [2:0][2:0] write_hold_cycles,
   input wire logic [2:0][1:0] turnaround_cycles,
   input wire logic [2:0] extended_wait_enable,
   input wire logic [2:0][7:0] max_wait_limit,
   input wire logic [2:0] select_strobe,
   // sdram settings and power control
   input wire logic sdram_wide32,
   input wire logic [1:0] sdram_banks,
   input wire logic [1:0] sdram_cols,
   input wire logic sdram_cl3,
   input wire logic sdram_selfref_req,
   input wire logic sdram_pdown_req,
   output logic sdram_in_selfref,
   output logic sdram_in_pdown,
   // memory pins
   output logic [2:0] memory_chip_select_n,
   output logic memory_output_enable_n,
   output logic memory_write_enable_n,
   input wire logic memory_wait_in,
   output logic [1:0] memory_bank_select,
   output logic [12:0] memory_address_out,
   output logic [31:0] memory_data_out,
   output logic memory_data_oe,
   input wire logic [31:0] memory_data_in,
   output logic [3:0] memory_byte_mask,
   output logic sdram_chip_select_n,
   output logic sdram_ras_n,
   output logic sdram_cas_n,
   output logic sdram_we_n,
   output logic sdram_cke
);

   emi_state_t s;
   emi_state_t n;

   // async word address: 16-bit parts drop the byte bit
   function automatic logic [23:0] async_word(input logic [23:0] a, input logic wide);
      return wide ? {1'b0, a[23:1]} : a;
   endfunction : async_word

   // sdram split into {bank, row, column}
   function automatic logic [27:0] sd_split(input logic [23:0] a, input logic w32,
                                            input logic [1:0] cols, input logic [1:0] banks);
      logic [23:0] wa;
      logic [23:0] rest;
      logic [23:0] mask;
      logic [4:0] cbits;
      logic [1:0] bk;
      logic [12:0] row;
      wa = w32 ? {2'b00, a[23:2]} : {1'b0, a[23:1]};
      cbits = 5'(COL_BASE) + {3'b000, cols};
      mask = (24'h000001 << cbits) - 24'h000001;
      rest = wa >> cbits;
      case (banks)
         2'h0: begin bk = 2'h0; row = rest[12:0]; end
         2'h1: begin bk = {1'b0, rest[0]}; row = rest[13:1]; end
         default: begin bk = rest[1:0]; row = rest[14:2]; end
      endcase
      return {bk, row, (wa[12:0] & mask[12:0])};
   endfunction : sd_split

   always_comb
   begin
      logic [27:0] sp;
      logic [23:0] wa;
      logic [1:0] c;
      logic [5:0] stb;
      n = s;
      sp = sd_split(s.l_addr, sdram_wide32, sdram_cols, sdram_banks);
      c = s.cur_cs;
      wa = '0;
      stb = '0;
      n.rvalid = 1'b0;
      n.rtmo = 1'b0;
      // wait input: a change counts once the last two stages agree
      n.wsync = {s.wsync[1:0], memory_wait_in};
      if (s.wsync[1] == s.wsync[2])
         n.wait_q = s.wsync[2];
      // refresh interval runs except while the part refreshes itself
      if (s.st != SD_SELF)
      begin
         if (s.refi == 10'h000)
         begin
            n.refi = REFI_CYC;
            n.ref_due = 1'b1;
         end
         else
            n.refi = s.refi - 10'h001;
      end
      case (s.st)
         ST_IDLE:
         begin
            n.cmd = CMD_NOP;
            if (s.ref_due)
            begin
               n.cmd = CMD_REF;
               n.ref_due = (s.refi == 10'h000);
               n.st = SD_RFC;
               n.cnt = RFC_CYC - 8'h01;
            end
            else if (sdram_selfref_req)
            begin
               n.cmd = CMD_REF;
               n.cke = 1'b0;
               n.st = SD_SELF;
               n.in_self = 1'b1;
            end
            else if (req_valid && s.ready)
            begin
               n.wr = req_write;
               n.l_addr = req_addr;
               n.tmo = 1'b0;
               n.dout = req_wdata;
               n.doe = req_write;
               n.dqm = req_write ? ~req_be : 4'h0;
               if (req_sdram)
               begin
                  sp = sd_split(req_addr, sdram_wide32, sdram_cols, sdram_banks);
                  n.cmd = CMD_ACT;
                  n.ba = sp[27:26];
                  n.addr = sp[25:13];
                  if (!sdram_wide32)
                     n.dqm[3:2] = 2'h3;
                  n.st = SD_RCD;
                  n.cnt = RCD_CYC - 8'h01;
               end
               else
               begin
                  c = (req_cs == 2'h3) ? 2'h2 : req_cs;
                  n.cur_cs = c;
                  wa = async_word(req_addr, async_wide[c]);
                  n.addr = wa[12:0];
                  n.ba = wa[14:13];
                  if (!select_strobe[c])
                     n.cs_n[c] = 1'b0;
                  n.cnt = {4'h0, req_write ? write_setup_cycles[c] : read_setup_cycles[c]};
                  n.st = ST_SETUP;
               end
            end
            else if (sdram_pdown_req)
            begin
               n.cke = 1'b0;
               n.st = SD_PDN;
               n.in_pdn = 1'b1;
            end
         end
         ST_SETUP:
         begin
            if (s.cnt == 8'h00)
            begin
               stb = s.wr ? write_strobe_cycles[c] : read_strobe_cycles[c];
               if (!s.wr && stb < RD_STROBE_MIN)
                  stb = RD_STROBE_MIN;
               n.cnt = {2'b00, stb};
               n.oe_n = s.wr;
               n.we_n = !s.wr;
               n.cs_n[c] = 1'b0;
               n.st = ST_STROBE;
            end
            else
               n.cnt = s.cnt - 8'h01;
         end
         ST_STROBE:
         begin
            if (s.cnt == 8'h00)
            begin
               n.rdata = memory_data_in;
               // wait is judged where hold would begin, before any inserted cycle
               if (extended_wait_enable[c] && s.wait_q)
               begin
                  n.st = ST_XWAIT;
                  n.chunk = WAIT_CHUNK_LAST;
                  n.extended_wait_count = '0;
               end
               else
               begin
                  n.st = ST_HOLD;
                  n.oe_n = 1'b1;
                  n.we_n = 1'b1;
                  if (select_strobe[c])
                     n.cs_n = 3'h7;
                  n.cnt = {5'h00, s.wr ? write_hold_cycles[c] : read_hold_cycles[c]};
               end
            end
            else
               n.cnt = s.cnt - 8'h01;
         end
         ST_XWAIT:
         begin
            if (s.chunk == 4'h0)
            begin
               n.extended_wait_count = s.extended_wait_count + 9'h001;
               n.chunk = WAIT_CHUNK_LAST;
               n.rdata = memory_data_in;
               if (s.extended_wait_count[7:0] == max_wait_limit[c] || !s.wait_q)
               begin
                  n.tmo = s.wait_q;
                  n.st = ST_HOLD;
                  n.oe_n = 1'b1;
                  n.we_n = 1'b1;
                  if (select_strobe[c])
                     n.cs_n = 3'h7;
                  n.cnt = {5'h00, s.wr ? write_hold_cycles[c] : read_hold_cycles[c]};
               end
            end
            else
               n.chunk = s.chunk - 4'h1;
         end
         ST_HOLD:
         begin
            if (s.cnt == 8'h00)
            begin
               n.cs_n = 3'h7;
               n.doe = 1'b0;
               n.dqm = 4'h0;
               n.rvalid = 1'b1;
               n.rtmo = s.tmo;
               n.st = ST_TURN;
               n.cnt = {6'h00, turnaround_cycles[c]};
            end
            else
               n.cnt = s.cnt - 8'h01;
         end
         ST_TURN:
         begin
            if (s.cnt == 8'h00)
               n.st = ST_IDLE;
            else
               n.cnt = s.cnt - 8'h01;
         end
         SD_RCD:
         begin
            n.cmd = CMD_NOP;
            if (s.cnt == 8'h00)
            begin
               n.cmd = s.wr ? CMD_WR : CMD_RD;
               n.addr = {sp[11:10], 1'b0, sp[9:0]}; // column bit ten moves above the flag
               n.addr[PRE_ALL_BIT] = 1'b0;
               n.st = SD_LAT;
               n.cnt = s.wr ? 8'h00 : (sdram_cl3 ? CL3_CYC : CL2_CYC);
            end
            else
               n.cnt = s.cnt - 8'h01;
         end
         SD_LAT:
         begin
            n.cmd = CMD_NOP;
            n.doe = 1'b0;
            if (s.cnt == 8'h00)
            begin
               n.rdata = memory_data_in;
               if (!sdram_wide32)
                  n.rdata[31:16] = 16'h0000;
               n.rvalid = 1'b1;
               // close the row at once: single access only
               n.cmd = CMD_PRE;
               n.addr[PRE_ALL_BIT] = 1'b1;
               n.dqm = 4'h0;
               n.st = SD_RP;
               n.cnt = RP_CYC - 8'h01;
            end
            else
               n.cnt = s.cnt - 8'h01;
         end
         SD_RP, SD_RFC:
         begin
            n.cmd = CMD_NOP;
            if (s.cnt == 8'h00)
               n.st = ST_IDLE;
            else
               n.cnt = s.cnt - 8'h01;
         end
         SD_SELF:
         begin
            n.cmd = CMD_NOP;
            if (!sdram_selfref_req)
            begin
               n.cke = 1'b1;
               n.in_self = 1'b0;
               n.st = SD_RFC;
               n.cnt = RFC_CYC - 8'h01;
            end
         end
         SD_PDN:
         begin
            n.cmd = CMD_NOP;
            // wake for refresh keeps contents while powered down
            if (s.ref_due || !sdram_pdown_req || req_valid)
            begin
               n.cke = 1'b1;
               n.in_pdn = 1'b0;
               n.st = ST_IDLE;
            end
         end
         default:
            n = ST_RESET;
      endcase
      n.ready = (n.st == ST_IDLE) && !n.ref_due && !sdram_selfref_req;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         s <= ST_RESET;
      else
         s <= n;
   end

   assign req_ready = s.ready;
   assign rsp_valid = s.rvalid;
   assign rsp_rdata = s.rdata;
   assign rsp_timeout = s.rtmo;
   assign sdram_in_selfref = s.in_self;
   assign sdram_in_pdown = s.in_pdn;
   assign memory_chip_select_n = s.cs_n;
   assign memory_output_enable_n = s.oe_n;
   assign memory_write_enable_n = s.we_n;
   assign memory_bank_select = s.ba;
   assign memory_address_out = s.addr;
   assign memory_data_out = s.dout;
   assign memory_data_oe = s.doe;
   assign memory_byte_mask = s.dqm;
   assign sdram_chip_select_n = s.cmd[3];
   assign sdram_ras_n = s.cmd[2];
   assign sdram_cas_n = s.cmd[1];
   assign sdram_we_n = s.cmd[0];
   assign sdram_cke = s.cke;

endmodule : emi_core

// *** include/emi_pkg.sv ***
// constants, state and types of the external memory controller
package emi_pkg;
   localparam int CLK_NS = 20;
   function automatic int cyc_min(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_min
   function automatic int cyc_max(input int ns);
      int c;
      c = ns / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_max
   localparam int T_RCD_NS = 20;
   localparam int T_RP_NS = 20;
   localparam int T_RFC_NS = 70;
   localparam int T_REFI_NS = 7800;
   localparam logic [7:0] RCD_CYC = 8'(cyc_min(T_RCD_NS));
   localparam logic [7:0] RP_CYC = 8'(cyc_min(T_RP_NS));
   localparam logic [7:0] RFC_CYC = 8'(cyc_min(T_RFC_NS));
   localparam logic [9:0] REFI_CYC = 10'(cyc_max(T_REFI_NS));
   localparam logic [3:0] WAIT_CHUNK_LAST = 4'hf;
   localparam logic [5:0] RD_STROBE_MIN = 6'h03;
   localparam logic [7:0] CL2_CYC = 8'h02;
   localparam logic [7:0] CL3_CYC = 8'h03;
   localparam logic [7:0] COL_BASE = 8'h08;
   localparam int PRE_ALL_BIT = 10;
   // {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_DESEL = 4'hf;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   typedef enum logic [3:0] {
      ST_IDLE, ST_TURN, ST_SETUP, ST_STROBE, ST_XWAIT, ST_HOLD,
      SD_RCD, SD_LAT, SD_RP, SD_RFC, SD_SELF, SD_PDN
   } emi_state_e_t;
   typedef struct packed {
      emi_state_e_t st;
      logic [7:0] cnt;
      logic [3:0] chunk;
      logic [8:0] extended_wait_count;
      logic [1:0] cur_cs;
      logic wr;
      logic tmo;
      logic [2:0] wsync;
      logic wait_q;
      logic [9:0] refi;
      logic ref_due;
      logic [23:0] l_addr;
      logic [2:0] cs_n;
      logic oe_n;
      logic we_n;
      logic [1:0] ba;
      logic [12:0] addr;
      logic [31:0] dout;
      logic doe;
      logic [3:0] dqm;
      logic [3:0] cmd;
      logic cke;
      logic ready;
      logic rvalid;
      logic [31:0] rdata;
      logic rtmo;
      logic in_self;
      logic in_pdn;
   } emi_state_t;
   localparam emi_state_t ST_RESET = '{st: ST_IDLE, cs_n: 3'h7, oe_n: 1'b1, we_n: 1'b1,
      cmd: CMD_DESEL, cke: 1'b1, refi: REFI_CYC, default: '0};
endpackage : emi_pkg

// *** tb/emi_core_asserts.sv ***
// pin-level assertions for the memory controller
`timescale 1ns/1ps
module emi_core_asserts
   import emi_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // request side and settings
   input wire logic req_ready,
   input wire logic rsp_valid,
   input wire logic [2:0] select_strobe,
   input wire logic sdram_wide32,
   input wire logic sdram_cl3,
   input wire logic sdram_in_selfref,
   // memory pins
   input wire logic [2:0] memory_chip_select_n,
   input wire logic memory_output_enable_n,
   input wire logic memory_write_enable_n,
   input wire logic [1:0] memory_bank_select,
   input wire logic [12:0] memory_address_out,
   input wire logic [31:0] memory_data_out,
   input wire logic memory_data_oe,
   input wire logic [3:0] memory_byte_mask,
   input wire logic sdram_chip_select_n,
   input wire logic sdram_ras_n,
   input wire logic sdram_cas_n,
   input wire logic sdram_we_n,
   input wire logic sdram_cke
);
   logic [3:0] cmd;
   assign cmd = {sdram_chip_select_n, sdram_ras_n, sdram_cas_n, sdram_we_n};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   property p_one_sel; $onehot0(~memory_chip_select_n); endproperty
   property p_sel_span;
      !(memory_output_enable_n && memory_write_enable_n) |-> !(&memory_chip_select_n);
   endproperty
   property p_ss_edge; select_strobe[1] && $fell(memory_chip_select_n[1])
      |-> $fell(memory_output_enable_n) || $fell(memory_write_enable_n); endproperty
   property p_rd_addr; !memory_output_enable_n
      |-> $stable(memory_address_out) && $stable(memory_bank_select); endproperty
   property p_wr_data; !memory_write_enable_n
      |-> memory_data_oe && $stable(memory_data_out) && $stable(memory_byte_mask); endproperty
   property p_no_burst; cmd == CMD_RD |=> (cmd != CMD_RD) [*4]; endproperty
   property p_cl2; cmd == CMD_RD && !sdram_cl3 |-> ##3 rsp_valid; endproperty
   property p_cl3; cmd == CMD_RD && sdram_cl3 |-> ##4 rsp_valid; endproperty
   // turnaround keeps the bus quiet before the next request is taken
   property p_turn; $rose(&memory_chip_select_n)
      |-> !req_ready ##1 (&memory_chip_select_n); endproperty
   property p_selfref; sdram_in_selfref |-> !sdram_cke; endproperty
   property p_mask16; cmd == CMD_WR && !sdram_wide32 |-> memory_byte_mask[3:2] == 2'h3;
   endproperty
   a_one_sel: assert property (p_one_sel) else $error("two selects low");
   a_sel_span: assert property (p_sel_span) else $error("strobe without select");
   a_ss_edge: assert property (p_ss_edge) else $error("select not with strobe");
   a_rd_addr: assert property (p_rd_addr) else $error("address moved in read");
   a_wr_data: assert property (p_wr_data) else $error("write data moved");
   a_no_burst: assert property (p_no_burst) else $error("burst read");
   a_cl2: assert property (p_cl2) else $error("latency two wrong");
   a_cl3: assert property (p_cl3) else $error("latency three wrong");
   a_turn: assert property (p_turn) else $error("no turnaround");
   a_selfref: assert property (p_selfref) else $error("clock on in self refresh");
   a_mask16: assert property (p_mask16) else $error("upper lanes open");
   c_cl3: cover property (cmd == CMD_RD && sdram_cl3);
   c_ss: cover property (select_strobe[1] && $fell(memory_chip_select_n[1]));
   c_selfref: cover property (sdram_in_selfref);
endmodule : emi_core_asserts
bind emi_core emi_core_asserts emi_core_asserts_inst (.*);

// *** tb/emi_mem_model.sv ***
// behavioural async memory on the far side of the controller
`timescale 1ns/1ps
module emi_mem_model (
   // clock
   input wire logic clk,
   // controller pins
   input wire logic [2:0] cs_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic [12:0] addr,
   input wire logic [31:0] wdata,
   input wire logic [3:0] mask,
   // wait length per read, zero or at least two
   input wire logic [31:0] stall,
   output logic [31:0] rdata,
   output logic wait_out
);
   logic [31:0] mem [256];
   logic [31:0] last = 32'h0;
   logic oe_q = 1'b1;
   int wcnt = 0;
   always @(posedge clk)
   begin
      oe_q <= oe_n;
      if (!we_n && cs_n != 3'h7)
      begin
         for (int i = 0; i < 4; i++)
            if (!mask[i]) mem[addr[7:0]][8*i +: 8] <= wdata[8*i +: 8];
      end
      if (!oe_n) last <= rdata;
      if (oe_q && !oe_n) wcnt <= stall;
      else if (wcnt > 0) wcnt <= wcnt - 1;
   end
   // raised one cycle after the strobe starts, well ahead of hold
   assign wait_out = wcnt > 0;
   // released bus shows the inverse, so a stale sample is caught
   assign rdata = (!oe_n && cs_n != 3'h7) ? mem[addr[7:0]] : ~last;
endmodule : emi_mem_model

// *** tb/external_memory_interface_tb.sv ***
// self-checking bench for the external memory controller
`timescale 1ns/1ps
module external_memory_interface_tb;
   import emi_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0, req_write = 1'b0, req_sdram = 1'b0;
   logic [1:0] req_cs = 2'h0;
   logic [23:0] req_addr = 24'h0;
   logic [31:0] req_wdata = 32'h0;
   logic [3:0] req_be = 4'hf;
   logic req_ready, rsp_valid, rsp_timeout;
   logic [31:0] rsp_rdata, memory_data_out, memory_data_in, rd;
   // cs2 plain, cs3 select-strobe and 16-bit, cs4 extended wait
   logic [2:0] async_wide = 3'h2, extended_wait_enable = 3'h4, select_strobe = 3'h2;
   logic [2:0][3:0] read_setup_cycles = {4'h0, 4'h0, 4'h1}, write_setup_cycles = 12'h000;
   logic [2:0][5:0] read_strobe_cycles = {6'h07, 6'h01, 6'h03};
   logic [2:0][5:0] write_strobe_cycles = {6'h00, 6'h00, 6'h02};
   logic [2:0][2:0] read_hold_cycles = {3'h0, 3'h2, 3'h0};
   logic [2:0][2:0] write_hold_cycles = {3'h0, 3'h0, 3'h1};
   logic [2:0][1:0] turnaround_cycles = {2'h0, 2'h3, 2'h0};
   logic [2:0][7:0] max_wait_limit = {8'h01, 8'h00, 8'h00};
   logic sdram_wide32 = 1'b1, sdram_cl3 = 1'b0;
   logic sdram_selfref_req = 1'b0, sdram_pdown_req = 1'b0;
   logic [1:0] sdram_banks = 2'h0, sdram_cols = 2'h0;
   logic sdram_in_selfref, sdram_in_pdown, memory_output_enable_n, memory_write_enable_n;
   logic memory_wait_in, memory_data_oe, sdram_cke;
   logic sdram_chip_select_n, sdram_ras_n, sdram_cas_n, sdram_we_n;
   logic [2:0] memory_chip_select_n;
   logic [1:0] memory_bank_select;
   logic [12:0] memory_address_out;
   logic [3:0] memory_byte_mask, cmd;
   logic [14:0] act;
   logic [12:0] col;
   int stall = 0;
   int n_fail = 0;
   int n_tests = 0;
   assign cmd = {sdram_chip_select_n, sdram_ras_n, sdram_cas_n, sdram_we_n};
   emi_core emi_core_inst (.*);
   emi_mem_model emi_mem_model_inst (.clk(clk), .cs_n(memory_chip_select_n),
      .oe_n(memory_output_enable_n), .we_n(memory_write_enable_n),
      .addr(memory_address_out), .wdata(memory_data_out), .mask(memory_byte_mask),
      .stall(stall), .rdata(memory_data_in), .wait_out(memory_wait_in));
   initial
   begin
      forever #10 clk = ~clk;
   end
   task automatic step();
      @(posedge clk);
      #1;
   endtask : step
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chn(input int got, input int exp);
      n_tests++;
      if (got != exp)
      begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chn
   task automatic bound(input int k, input int n);
      if (k >= n)
      begin
         n_fail++;
         finish_test();
      end
   endtask : bound
   // one access: latency, select-low cycles and gap to next ready
   task automatic acc(input logic w, input logic s, input logic [1:0] c,
      input logic [23:0] a, input logic [31:0] d, input logic [3:0] be,
      input int lat, input int lo, input int gap, input logic tmo);
      int k;
      int g;
      int n;
      logic rdy;
      logic rf;
      n = 0;
      {act, col} = '1;
      rf = 1'b0;
      rdy = 1'b0;
      {req_write, req_sdram, req_cs, req_addr, req_wdata, req_be} = {w, s, c, a, d, be};
      req_valid = 1'b1;
      for (k = 0; k < 500 && rdy !== 1'b1; k++)
      begin
         rdy = req_ready;
         step();
      end
      bound(k, 500);
      req_valid = 1'b0;
      for (k = 1; k < 300 && rsp_valid !== 1'b1; k++)
      begin
         if (memory_chip_select_n[c] === 1'b0) n++;
         if (cmd === CMD_ACT) act = {memory_bank_select, memory_address_out};
         if (cmd === CMD_RD || cmd === CMD_WR) col = memory_address_out;
         step();
      end
      bound(k, 300);
      chn(k, lat);
      chn(n, lo);
      chk(32'(rsp_timeout), 32'(tmo));
      rd = rsp_rdata;
      // a refresh landing here stretches the gap legitimately
      for (g = 0; g < 300 && req_ready !== 1'b1; g++)
      begin
         step();
         if (cmd === CMD_REF) rf = 1'b1;
      end
      chn(rf ? gap : g, gap);
   endtask : acc
   task automatic t_reset();
      rst = 1'b1;
      repeat (6) step();
      chk(32'({memory_chip_select_n, memory_output_enable_n, memory_write_enable_n, cmd,
         sdram_cke, req_ready}), 32'h7fe);
      rst = 1'b0;
   endtask : t_reset
   task automatic t_async();
      acc(1'b1, 1'b0, 2'h0, 24'h10, 32'h11223344, 4'hf, 7, 6, 1, 1'b0);
      acc(1'b1, 1'b0, 2'h0, 24'h10, 32'haabbccdd, 4'h5, 7, 6, 1, 1'b0);
      acc(1'b0, 1'b0, 2'h0, 24'h10, 32'h0, 4'hf, 8, 7, 1, 1'b0);
      chk(rd, 32'h11bb33dd);
      acc(1'b1, 1'b0, 2'h1, 24'h40, 32'h5a5a0ff0, 4'hf, 4, 1, 4, 1'b0);
      acc(1'b0, 1'b0, 2'h1, 24'h40, 32'h0, 4'hf, 9, 4, 4, 1'b0);
      chk(rd, 32'h5a5a0ff0);
   endtask : t_async
   task automatic t_wait();
      stall = 12;
      acc(1'b0, 1'b0, 2'h2, 24'h30, 32'h0, 4'hf, 27, 26, 1, 1'b0);
      stall = 80;
      acc(1'b0, 1'b0, 2'h2, 24'h30, 32'h0, 4'hf, 43, 42, 1, 1'b1);
      stall = 0;
      repeat (60) step();
   endtask : t_wait
   task automatic t_sdram();
      // word 123456: {bank, row} at activate, column at read, per column width
      logic [14:0] ea [4] = '{15'h1234, 15'h048d, 15'h2123, 15'h4091};
      logic [12:0] ec [4] = '{13'h056, 13'h056, 13'h056, 13'h856};
      for (int i = 0; i < 4; i++)
      begin
         sdram_cols = 2'(i);
         sdram_banks = 2'(i);
         sdram_cl3 = i[0];
         acc(1'b0, 1'b1, 2'h0, 24'h48d158, 32'h0, 4'hf, i[0] ? 6 : 5, 0, 1, 1'b0);
         chk(32'(act), 32'(ea[i]));
         chk(32'(col), 32'(ec[i]));
      end
      sdram_wide32 = 1'b0;
      acc(1'b1, 1'b1, 2'h0, 24'h104, 32'h1234, 4'hf, 3, 0, 1, 1'b0);
      acc(1'b0, 1'b1, 2'h0, 24'h104, 32'h0, 4'hf, 6, 0, 1, 1'b0);
      chk(rd & 32'hffff0000, 32'h0);
      sdram_wide32 = 1'b1;
   endtask : t_sdram
   task automatic t_power();
      int k;
      sdram_selfref_req = 1'b1;
      for (k = 0; k < 100 && sdram_in_selfref !== 1'b1; k++) step();
      bound(k, 100);
      chk(32'({sdram_in_selfref, sdram_cke}), 32'h2);
      sdram_selfref_req = 1'b0;
      for (k = 0; k < 100 && req_ready !== 1'b1; k++) step();
      bound(k, 100);
      chk(32'({sdram_in_selfref, sdram_cke}), 32'h1);
      sdram_pdown_req = 1'b1;
      for (k = 0; k < 100 && sdram_in_pdown !== 1'b1; k++) step();
      bound(k, 100);
      chk(32'({sdram_in_pdown, sdram_cke}), 32'h2);
      for (k = 0; k < 500 && cmd !== CMD_REF; k++) step();
      bound(k, 500);
      sdram_pdown_req = 1'b0;
      for (k = 0; k < 100 && req_ready !== 1'b1; k++) step();
      bound(k, 100);
   endtask : t_power
   initial
   begin
      t_reset();
      t_async();
      t_wait();
      t_sdram();
      t_power();
      t_reset();
      t_async();
      finish_test();
   end
endmodule : external_memory_interface_tb
